// ==== tb/tb_rtcc_top.sv ====
// tb_rtcc_top: self-checking bench of the real-time counter registers
`timescale 1ns/1ns
module tb_rtcc_top;
  import rtcc_pkg::*;

  localparam int LIMIT = 20000;

  logic clk_sys;
  logic reset_n;
  logic slow_clk;
  logic standby;
  logic debug_halt;
  rtcc_req_t req;
  logic [DATA_W-1:0] rdata;
  logic irq;
  rtcc_evt_t evt;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_match_evt = 0;
  int n_wrap_evt = 0;
  logic [15:0] v;

  rtcc_top i_dut (
    .CLK_SYS_I(clk_sys),
    .RESET_N_I(reset_n),
    .SLOW_CLK_I(slow_clk),
    .STANDBY_I(standby),
    .DEBUG_HALT_I(debug_halt),
    .REG_REQ_I(req),
    .REG_RDATA_O(rdata),
    .IRQ_O(irq),
    .EVT_O(evt)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event pulse counting and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (evt.match === 1'b1) n_match_evt++;
    if (evt.wrap === 1'b1) n_wrap_evt++;
    if (cycles == LIMIT) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rchk

  // low byte first so the staging byte carries it into the high write
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] val);
    wr(a, val[7:0]);
    wr(ADDR_W'(a + 1), val[15:8]);
  endtask : wr16

  task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] val);
    rd(a, val[7:0]);
    rd(ADDR_W'(a + 1), val[15:8]);
  endtask : rd16

  // slow clock runs only here; idle low between bursts
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      slow_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      slow_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : tick

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0, irq}, {15'h0, exp});
  endtask : irq_chk

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rchk(OFF_CTRL, 8'h00);
    rchk(OFF_STATUS, 8'h00);
    rchk(OFF_IRQ_EN, 8'h00);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    rd16(OFF_TOP_LO, v);
    chk(v, RST_TOP);
    rchk(OFF_STAGING, 8'hFF);
    wr(OFF_STAGING, 8'h5A);
    rchk(OFF_STAGING, 8'h5A);
    wr(5'h06, 8'hFF);
    rchk(5'h06, 8'h00);
    wr(OFF_STATUS, 8'hFF);
    rchk(OFF_STATUS, 8'h00);
    wr(OFF_IRQ_EN, 8'hFF);
    rchk(OFF_IRQ_EN, 8'h03);
    wr(OFF_IRQ_EN, 8'h00);
  endtask : t_reset

  task automatic t_sync;
    wr(OFF_CTRL, 8'h01);
    rchk(OFF_STATUS, 8'h01);
    wr(OFF_TOP_LO, 8'h03);
    rchk(OFF_STAGING, 8'h03);
    wr(OFF_TOP_HI, 8'h00);
    rchk(OFF_STATUS, 8'h05);
    wr16(OFF_MATCH_LO, 16'h0002);
    rchk(OFF_STATUS, 8'h0D);
    wr16(OFF_COUNT_LO, 16'h0000);
    rchk(OFF_STATUS, 8'h0F);
    tick(1);
    rchk(OFF_STATUS, 8'h00);
    rchk(OFF_CTRL, 8'h01);
    rd16(OFF_TOP_LO, v);
    chk(v, 16'h0003);
    rd16(OFF_MATCH_LO, v);
    chk(v, 16'h0002);
  endtask : t_sync

  task automatic t_count;
    wr(OFF_IRQ_EN, 8'h03);
    tick(2);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h0002);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    tick(1);
    rchk(OFF_IRQ_FLAGS, 8'h02);
    tick(1);
    rchk(OFF_IRQ_FLAGS, 8'h03);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h0000);
    irq_chk(1'b1);
    chk(16'(n_match_evt), 16'h0001);
    chk(16'(n_wrap_evt), 16'h0001);
    wr(OFF_IRQ_FLAGS, 8'h00);
    rchk(OFF_IRQ_FLAGS, 8'h03);
    wr(OFF_IRQ_FLAGS, 8'h02);
    rchk(OFF_IRQ_FLAGS, 8'h01);
    irq_chk(1'b1);
    wr(OFF_IRQ_EN, 8'h02);
    irq_chk(1'b0);
    wr(OFF_IRQ_EN, 8'h01);
    irq_chk(1'b1);
    wr(OFF_IRQ_FLAGS, 8'h01);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    irq_chk(1'b0);
  endtask : t_count

  // divide by two: any four ticks hold exactly two steps whatever the phase
  task automatic t_prescale;
    wr(OFF_CTRL, 8'h09);
    wr16(OFF_COUNT_LO, 16'h0000);
    tick(1);
    rchk(OFF_STATUS, 8'h00);
    tick(4);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h0002);
    rchk(OFF_CTRL, 8'h09);
  endtask : t_prescale

  task automatic t_standby;
    @(posedge clk_sys);
    standby <= 1'b1;
    wr(OFF_CTRL, 8'h01);
    wr16(OFF_COUNT_LO, 16'h0000);
    tick(4);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h0000);
    wr(OFF_CTRL, 8'h81);
    wr16(OFF_COUNT_LO, 16'h0000);
    tick(3);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h0002);
    @(posedge clk_sys);
    standby <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    wr16(OFF_COUNT_LO, 16'h1234);
    tick(4);
    rd16(OFF_COUNT_LO, v);
    chk(v, 16'h1234);
  endtask : t_standby

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    req = '0;
    slow_clk = 1'b0;
    standby = 1'b0;
    debug_halt = 1'b0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_sync();
    t_count();
    t_prescale();
    t_standby();
    stop_test();
  end

endmodule : tb_rtcc_top

// ==== verilog/rtcc_pkg.sv ====
// rtcc_pkg: constants, register map and carrier types of the real-time counter block
// Operation
// RULE_01 - Control bits 6:3 divide the slow clock by two to the field value.
// RULE_02 - Control bit 7 set keeps counting in standby, cleared stops it.
// RULE_03 - Control bit 0 enables the counter; resets to zero.
// RULE_04 - Status bit 3 is high while a match value is moving to slow domain.
// RULE_05 - Status bit 2 is high while a top value is moving to slow domain.
// RULE_06 - Status bit 1 is high while a count value is moving to slow domain.
// RULE_07 - Status bit 0 is high while a control write is moving to slow domain.
// RULE_08 - Interrupt enable bit 1 allows a request when count equals match value.
// RULE_09 - Interrupt enable bit 0 allows a request when count hits top and wraps.
// RULE_10 - Flag bit 1 set on match; writing one clears it, zero does nothing.
// RULE_11 - Counter wraps to zero after top and sets flag bit 0; one clears it.
// RULE_12 - One software-visible staging byte is shared by all 16-bit registers.
// RULE_13 - Counting follows the separate slow clock; register updates lag by synchronisation.
// RULE_14 - Request stays high while a source is enabled and its flag set.
// RULE_15 - Match and wrap requests are ORed onto one interrupt line.
// RULE_16 - An enabled interrupt source also enables its event pulse output.
// RULE_17 - Low-byte write staged, committed with high byte; low read latches high byte.
package rtcc_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int DIV_W = 4;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h01;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_STAGING = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_HALT = 5'h05;
  localparam logic [ADDR_W-1:0] OFF_CLK_SEL = 5'h07;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 5'h09;
  localparam logic [ADDR_W-1:0] OFF_TOP_LO = 5'h0A;
  localparam logic [ADDR_W-1:0] OFF_TOP_HI = 5'h0B;
  localparam logic [ADDR_W-1:0] OFF_MATCH_LO = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_MATCH_HI = 5'h0D;
  localparam logic [ADDR_W-1:0] OFF_PIT_CTRL = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PIT_STATUS = 5'h11;
  localparam logic [ADDR_W-1:0] OFF_PIT_IRQ_EN = 5'h12;
  localparam logic [ADDR_W-1:0] OFF_PIT_FLAGS = 5'h13;
  localparam logic [ADDR_W-1:0] OFF_PIT_HALT = 5'h15;

  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIV_LSB = 3;
  localparam int CTRL_STBY_BIT = 7;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 8'hF9;

  // busy bits in the status register
  localparam int BUSY_CTRL_BIT = 0;
  localparam int BUSY_COUNT_BIT = 1;
  localparam int BUSY_TOP_BIT = 2;
  localparam int BUSY_MATCH_BIT = 3;

  // interrupt enable and flag positions
  localparam int SRC_WRAP_BIT = 0;
  localparam int SRC_MATCH_BIT = 1;

  localparam logic [DATA_W-1:0] HALT_WMASK = 8'h01;
  localparam logic [DATA_W-1:0] CLK_SEL_WMASK = 8'h03;
  localparam logic [DATA_W-1:0] PIT_CTRL_WMASK = 8'h79;
  localparam logic [DATA_W-1:0] PIT_IRQ_WMASK = 8'h01;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CNT_W-1:0] RST_TOP = 16'hFFFF;
  localparam logic [CNT_W-1:0] RST_MATCH = 16'h0000;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [3:0] RST_BUSY = 4'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rtcc_req_t;

  typedef struct packed {
    logic match;
    logic wrap;
  } rtcc_evt_t;

endpackage : rtcc_pkg

// ==== verilog/rtcc_prescaler.sv ====
// rtcc_prescaler: power-of-two divider of the slow clock ticks
`timescale 1ns/1ns
module rtcc_prescaler
  import rtcc_pkg::*;
#(
  parameter int PRE_W = 15
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic step_o
);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  wire logic [PRE_W-1:0] mask = PRE_W'((32'h1 << div_i) - 32'h1);

  // counter is held clear while stopped so a restart begins a full period
  assign pre_nxt = !run_i ? '0 : (tick_i ? pre_r + PRE_W'(1) : pre_r);
  assign step_o = run_i && tick_i && ((pre_r & mask) == mask); // see RULE_01

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

endmodule : rtcc_prescaler

// ==== verilog/rtcc_top.sv ====
// rtcc_top: register file, synchronisation and 16-bit counter of the real-time counter
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module rtcc_top (
  // system
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // slow timing clock and power state pins
  input wire logic SLOW_CLK_I,
  input wire logic STANDBY_I,
  input wire logic DEBUG_HALT_I,
  // register port
  input wire rtcc_pkg::rtcc_req_t REG_REQ_I,
  output logic [rtcc_pkg::DATA_W-1:0] REG_RDATA_O,
  // interrupt and events
  output logic IRQ_O,
  output rtcc_pkg::rtcc_evt_t EVT_O
);
  import rtcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // slow clock synchroniser and tick

  logic slow_s1_r;
  logic slow_s2_r;
  logic slow_s3_r;
  wire logic tick = slow_s2_r && !slow_s3_r; // see RULE_13

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
    end else begin
      slow_s1_r <= SLOW_CLK_I;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
    end
  end

  logic stby_s1_r;
  logic stby_s2_r;
  logic halt_s1_r;
  logic halt_s2_r;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stby_s1_r <= 1'b0;
      stby_s2_r <= 1'b0;
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
    end else begin
      stby_s1_r <= STANDBY_I;
      stby_s2_r <= stby_s1_r;
      halt_s1_r <= DEBUG_HALT_I;
      halt_s2_r <= halt_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr = REG_REQ_I.wr;
  wire logic rd = REG_REQ_I.rd;
  wire logic [ADDR_W-1:0] addr = REG_REQ_I.addr;
  wire logic [DATA_W-1:0] wdata = REG_REQ_I.wdata;

  wire logic wr_ctrl = wr && hit(addr, OFF_CTRL);
  wire logic wr_ie = wr && hit(addr, OFF_IRQ_EN);
  wire logic wr_flags = wr && hit(addr, OFF_IRQ_FLAGS);
  wire logic wr_stage = wr && hit(addr, OFF_STAGING);
  wire logic wr_halt = wr && hit(addr, OFF_HALT);
  wire logic wr_csel = wr && hit(addr, OFF_CLK_SEL);
  wire logic wr_pit_ctrl = wr && hit(addr, OFF_PIT_CTRL);
  wire logic wr_pit_ie = wr && hit(addr, OFF_PIT_IRQ_EN);
  wire logic wr_pit_halt = wr && hit(addr, OFF_PIT_HALT);
  wire logic wr_cnt_lo = wr && hit(addr, OFF_COUNT_LO);
  wire logic wr_top_lo = wr && hit(addr, OFF_TOP_LO);
  wire logic wr_cmp_lo = wr && hit(addr, OFF_MATCH_LO);
  wire logic wr_cnt_hi = wr && hit(addr, OFF_COUNT_HI);
  wire logic wr_top_hi = wr && hit(addr, OFF_TOP_HI);
  wire logic wr_cmp_hi = wr && hit(addr, OFF_MATCH_HI);
  wire logic rd_cnt_lo = rd && hit(addr, OFF_COUNT_LO);
  wire logic rd_top_lo = rd && hit(addr, OFF_TOP_LO);
  wire logic rd_cmp_lo = rd && hit(addr, OFF_MATCH_LO);

  ////////////////////////////////////////////////////////////////////////////////
  // software-side registers

  logic [DATA_W-1:0] ctrl_sw_r;
  logic [DATA_W-1:0] ctrl_act_r;
  logic [1:0] ie_r;
  logic [1:0] flags_r;
  logic [1:0] flags_nxt;
  logic [DATA_W-1:0] stage_r;
  logic [DATA_W-1:0] stage_nxt;
  logic [DATA_W-1:0] halt_r;
  logic [DATA_W-1:0] csel_r;
  logic [DATA_W-1:0] pit_ctrl_r;
  logic [DATA_W-1:0] pit_ie_r;
  logic [DATA_W-1:0] pit_halt_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] cnt_wr_r;
  logic [CNT_W-1:0] top_sw_r;
  logic [CNT_W-1:0] top_act_r;
  logic [CNT_W-1:0] cmp_sw_r;
  logic [CNT_W-1:0] cmp_act_r;
  logic [3:0] busy_r;
  logic [3:0] busy_nxt;

  // low byte lives in the staging register until the high byte arrives
  wire logic [CNT_W-1:0] word_in = {wdata, stage_r}; // see RULE_17

  wire logic [3:0] busy_set = {wr_cmp_hi, wr_top_hi, wr_cnt_hi, wr_ctrl};
  // a write landing on the transfer tick stays pending for the next one
  assign busy_nxt = busy_set | (tick ? 4'h0 : busy_r); // see RULE_04 see RULE_05 see RULE_06 see RULE_07

  always_comb begin
    stage_nxt = stage_r;
    if (wr_stage || wr_cnt_lo || wr_top_lo || wr_cmp_lo) begin
      stage_nxt = wdata; // see RULE_12 see RULE_17
    end else if (rd_cnt_lo) begin
      stage_nxt = cnt_r[15:8]; // see RULE_17
    end else if (rd_top_lo) begin
      stage_nxt = top_sw_r[15:8];
    end else if (rd_cmp_lo) begin
      stage_nxt = cmp_sw_r[15:8];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_sw_r <= RST_BYTE; // see RULE_03
      ie_r <= RST_FLAGS;
      stage_r <= RST_BYTE;
      halt_r <= RST_BYTE;
      csel_r <= RST_BYTE;
      pit_ctrl_r <= RST_BYTE;
      pit_ie_r <= RST_BYTE;
      pit_halt_r <= RST_BYTE;
      cnt_wr_r <= RST_COUNT;
      top_sw_r <= RST_TOP;
      cmp_sw_r <= RST_MATCH;
      busy_r <= RST_BUSY;
    end else begin
      stage_r <= stage_nxt;
      busy_r <= busy_nxt;
      if (wr_ctrl) ctrl_sw_r <= wdata & CTRL_WMASK;
      if (wr_ie) ie_r <= wdata[1:0];
      if (wr_halt) halt_r <= wdata & HALT_WMASK;
      if (wr_csel) csel_r <= wdata & CLK_SEL_WMASK;
      if (wr_pit_ctrl) pit_ctrl_r <= wdata & PIT_CTRL_WMASK;
      if (wr_pit_ie) pit_ie_r <= wdata & PIT_IRQ_WMASK;
      if (wr_pit_halt) pit_halt_r <= wdata & HALT_WMASK;
      if (wr_cnt_hi) cnt_wr_r <= word_in;
      if (wr_top_hi) top_sw_r <= word_in;
      if (wr_cmp_hi) cmp_sw_r <= word_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // slow-domain side: values taken over on a tick

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_act_r <= RST_BYTE;
      top_act_r <= RST_TOP;
      cmp_act_r <= RST_MATCH;
    end else if (tick) begin
      if (busy_r[BUSY_CTRL_BIT]) ctrl_act_r <= ctrl_sw_r; // see RULE_13
      if (busy_r[BUSY_TOP_BIT]) top_act_r <= top_sw_r;
      if (busy_r[BUSY_MATCH_BIT]) cmp_act_r <= cmp_sw_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter core

  // standby only halts the counter when the run-in-standby bit is clear
  wire logic stby_ok = !stby_s2_r || ctrl_act_r[CTRL_STBY_BIT]; // see RULE_02
  wire logic halt_ok = !halt_s2_r || halt_r[0];
  wire logic run = ctrl_act_r[CTRL_EN_BIT] && stby_ok && halt_ok; // see RULE_03
  wire logic [DIV_W-1:0] div = ctrl_act_r[CTRL_DIV_LSB +: DIV_W];
  wire logic step;

  rtcc_prescaler #(
    .PRE_W(15)
  ) u_prescaler (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .run_i(run),
    .tick_i(tick),
    .div_i(div),
    .step_o(step)
  );

  wire logic at_top = (cnt_r == top_act_r);
  wire logic at_cmp = (cnt_r == cmp_act_r);
  wire logic wrap_ev = step && at_top; // see RULE_11
  wire logic match_ev = step && at_cmp; // see RULE_10

  always_comb begin
    cnt_nxt = cnt_r;
    if (tick && busy_r[BUSY_COUNT_BIT]) begin
      cnt_nxt = cnt_wr_r; // see RULE_06
    end else if (step) begin
      cnt_nxt = at_top ? RST_COUNT : cnt_r + 16'h0001; // see RULE_11
    end
  end

  // hardware set wins over a write-one clear in the same cycle
  assign flags_nxt = {match_ev, wrap_ev} | (flags_r & ~(wr_flags ? wdata[1:0] : 2'h0)); // see RULE_10 see RULE_11

  // a fresh enable counts at once, so the request never lags a flag already set
  wire logic [1:0] ie_nxt = wr_ie ? wdata[1:0] : ie_r;
  wire logic [1:0] req = flags_nxt & ie_nxt; // see RULE_08 see RULE_09 see RULE_14

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cnt_r <= RST_COUNT;
      flags_r <= RST_FLAGS;
      IRQ_O <= 1'b0;
      EVT_O <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      flags_r <= flags_nxt;
      IRQ_O <= |req; // see RULE_15
      EVT_O.match <= match_ev && ie_r[SRC_MATCH_BIT]; // see RULE_16
      EVT_O.wrap <= wrap_ev && ie_r[SRC_WRAP_BIT]; // see RULE_16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  logic [DATA_W-1:0] rsel;

  always_comb begin
    case (addr)
      OFF_CTRL: rsel = ctrl_sw_r;
      OFF_STATUS: rsel = {4'h0, busy_r};
      OFF_IRQ_EN: rsel = {6'h00, ie_r};
      OFF_IRQ_FLAGS: rsel = {6'h00, flags_r};
      OFF_STAGING: rsel = stage_r;
      OFF_HALT: rsel = halt_r;
      OFF_CLK_SEL: rsel = csel_r;
      OFF_COUNT_LO: rsel = cnt_r[7:0];
      OFF_TOP_LO: rsel = top_sw_r[7:0];
      OFF_MATCH_LO: rsel = cmp_sw_r[7:0];
      // high bytes come from the staging byte caught by the low read
      OFF_COUNT_HI, OFF_TOP_HI, OFF_MATCH_HI: rsel = stage_r; // see RULE_17
      OFF_PIT_CTRL: rsel = pit_ctrl_r;
      OFF_PIT_IRQ_EN: rsel = pit_ie_r;
      OFF_PIT_HALT: rsel = pit_halt_r;
      default: rsel = RST_BYTE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= RST_BYTE;
    end else begin
      REG_RDATA_O <= rd ? rsel : RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_match_flag_set: assert property (match_ev |=> flags_r[SRC_MATCH_BIT]) // see RULE_10
    else $error("match flag not set after compare hit");

  a_wrap_to_zero: assert property (wrap_ev && !(tick && busy_r[BUSY_COUNT_BIT])
    |=> cnt_r == 16'h0000 && flags_r[SRC_WRAP_BIT]) // see RULE_11
    else $error("counter did not wrap with flag");

  a_flag_clear_w1c: assert property (wr_flags && wdata[SRC_MATCH_BIT] && !match_ev
    |=> !flags_r[SRC_MATCH_BIT]) // see RULE_10
    else $error("match flag survived write of one");

  a_flag_zero_keep: assert property (wr_flags && !wdata[SRC_WRAP_BIT] && flags_r[SRC_WRAP_BIT]
    |=> flags_r[SRC_WRAP_BIT]) // see RULE_11
    else $error("write of zero cleared wrap flag");

  a_irq_follows: assert property (IRQ_O == (|(flags_r & ie_r))) // see RULE_14 see RULE_15
    else $error("interrupt low with enabled flag set");

  a_ctrl_busy_pair: assert property (wr_ctrl // see RULE_07
    |=> busy_r[BUSY_CTRL_BIT] && ctrl_sw_r == ($past(wdata) & CTRL_WMASK))
    else $error("control busy not raised");

  a_ctrl_busy_done: assert property (busy_r[BUSY_CTRL_BIT] && tick && !wr_ctrl // see RULE_07
    |=> !busy_r[BUSY_CTRL_BIT] && ctrl_act_r == $past(ctrl_sw_r))
    else $error("control value not transferred on tick");

  a_match_busy_done: assert property (busy_r[BUSY_MATCH_BIT] && tick && !wr_cmp_hi // see RULE_04
    |=> !busy_r[BUSY_MATCH_BIT] && cmp_act_r == $past(cmp_sw_r))
    else $error("match value not transferred on tick");

  a_top_busy_set: assert property (wr_top_hi |=> busy_r[BUSY_TOP_BIT] && top_sw_r == $past(word_in)) // see RULE_05
    else $error("top write not staged and pending");

  a_busy_done_tick: assert property (busy_r[BUSY_TOP_BIT] && tick && !wr_top_hi
    |=> !busy_r[BUSY_TOP_BIT] && top_act_r == $past(top_sw_r)) // see RULE_05
    else $error("top value not transferred on tick");

  a_cmp_busy_set: assert property (wr_cmp_hi |=> busy_r[BUSY_MATCH_BIT] && cmp_sw_r == $past(word_in)) // see RULE_04
    else $error("match write not staged and pending");

  a_cnt_busy_load: assert property (busy_r[BUSY_COUNT_BIT] && tick |=> cnt_r == $past(cnt_wr_r)) // see RULE_06
    else $error("count write not loaded on tick");

  a_stopped_hold: assert property (!run && !(tick && busy_r[BUSY_COUNT_BIT]) |=> $stable(cnt_r)) // see RULE_03
    else $error("counter moved while stopped");

  a_standby_stop: assert property (stby_s2_r && !ctrl_act_r[CTRL_STBY_BIT] |-> !step) // see RULE_02
    else $error("counter stepped in standby");

  a_div_one_step: assert property (run && tick && div == 4'h0 |-> step) // see RULE_01
    else $error("no division did not step every tick");

  a_read_window: assert property (!rd |=> REG_RDATA_O == 8'h00)
    else $error("read data outside read window");

  a_event_enable: assert property (EVT_O.match |-> $past(ie_r[SRC_MATCH_BIT])) // see RULE_16
    else $error("match event without enable");

  a_wrap_event: assert property (EVT_O.wrap |-> $past(ie_r[SRC_WRAP_BIT])) // see RULE_16
    else $error("wrap event without enable");

  c_wrap_seen: cover property (wrap_ev);
  c_match_irq: cover property (match_ev && ie_r[SRC_MATCH_BIT] ##1 IRQ_O);
  c_clear_race: cover property (wr_flags && wdata[SRC_WRAP_BIT] && wrap_ev);
  c_atomic_read: cover property (rd_cnt_lo ##2 rd && hit(addr, OFF_COUNT_HI));
  c_count_load: cover property (tick && busy_r[BUSY_COUNT_BIT]);

endmodule : rtcc_top
